// >>> bench/smps_props.sv
// assertions on the stop sequencer top ports, bound into the top
`timescale 1ns/1ps
module smps_props (
    // clock and reset
    input wire logic       CLK_SYS_I,
    input wire logic       NRST_I,
    // pin routing
    input wire logic [7:0] PIN_CTRL_I,
    input wire logic [7:0] PORT_CTRL_I,
    input wire logic       PERIPH_ENABLED_I,
    input wire logic [7:0] PIN_CTRL_O,
    input wire logic       PIN_LATCHED_O,
    // mode and event outputs
    input wire logic       DOMAIN_POWER_O,
    input wire logic       REGULATOR_FULL_O,
    input wire logic       DEBUG_CLK_ON_O,
    input wire logic       CPU_HALT_O,
    input wire logic       MODULE_RESET_O,
    input wire logic       RESET_VECTOR_O,
    input wire logic       IRQ_VECTOR_O,
    input wire logic       ILLEGAL_RESET_O,
    input wire logic       DEBUG_STATUS_ERR_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    property p_hold; PIN_LATCHED_O && $past(PIN_LATCHED_O) |-> $stable(PIN_CTRL_O); endproperty
    a_hold: assert property (p_hold) else $error("pins moved while latched");
    property p_off; !DOMAIN_POWER_O |-> PIN_LATCHED_O && CPU_HALT_O; endproperty
    a_off: assert property (p_off) else $error("power cut without pin latch");
    // the edge right after reset still shows the cleared register, so skip it
    property p_route; $past(NRST_I) && !PIN_LATCHED_O && !$past(PIN_LATCHED_O) |-> PIN_CTRL_O
        == ($past(PERIPH_ENABLED_I) ? $past(PIN_CTRL_I) : $past(PORT_CTRL_I)); endproperty
    a_route: assert property (p_route) else $error("open pin routing wrong");
    property p_rst; $rose(MODULE_RESET_O) |-> (MODULE_RESET_O && CPU_HALT_O) [*4]; endproperty
    a_rst: assert property (p_rst) else $error("wake reset too short");
    property p_vec; RESET_VECTOR_O |-> !IRQ_VECTOR_O ##1 !RESET_VECTOR_O; endproperty
    a_vec: assert property (p_vec) else $error("reset vector not a lone pulse");
    property p_irq; IRQ_VECTOR_O |-> !CPU_HALT_O && !MODULE_RESET_O; endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector while halted");
    property p_dbg; CPU_HALT_O && DEBUG_CLK_ON_O |-> REGULATOR_FULL_O && DOMAIN_POWER_O; endproperty
    a_dbg: assert property (p_dbg) else $error("debug stop lost regulation");
    property p_ill; ILLEGAL_RESET_O |-> !CPU_HALT_O ##1 !ILLEGAL_RESET_O && !CPU_HALT_O; endproperty
    a_ill: assert property (p_ill) else $error("illegal stop entered a stop");
    property p_err; DEBUG_STATUS_ERR_O |-> $past(CPU_HALT_O); endproperty
    a_err: assert property (p_err) else $error("status error outside stop");
endmodule

bind smps_top smps_props u_props (
    .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .PIN_CTRL_I(PIN_CTRL_I),
    .PORT_CTRL_I(PORT_CTRL_I), .PERIPH_ENABLED_I(PERIPH_ENABLED_I), .PIN_CTRL_O(PIN_CTRL_O),
    .PIN_LATCHED_O(PIN_LATCHED_O), .DOMAIN_POWER_O(DOMAIN_POWER_O),
    .REGULATOR_FULL_O(REGULATOR_FULL_O), .DEBUG_CLK_ON_O(DEBUG_CLK_ON_O),
    .CPU_HALT_O(CPU_HALT_O), .MODULE_RESET_O(MODULE_RESET_O), .RESET_VECTOR_O(RESET_VECTOR_O),
    .IRQ_VECTOR_O(IRQ_VECTOR_O), .ILLEGAL_RESET_O(ILLEGAL_RESET_O),
    .DEBUG_STATUS_ERR_O(DEBUG_STATUS_ERR_O)
);

// >>> bench/smps_top_tb.sv
// self-checking bench for the stop mode power sequencer
`timescale 1ns/1ps
module smps_top_tb;
    import smps_pkg::*;
    localparam logic [31:0] PARTIAL_POWERDOWN_CONTROL = 32'h1 << PARTIAL_POWERDOWN_CONTROL_BIT, ACK = 32'h1 << POWERDOWN_ACKNOWLEDGE_BIT;
    localparam logic [31:0] POWERDOWN_RECOVERY_FLAG = 32'h1 << POWERDOWN_RECOVERY_FLAG_BIT, LOW_POWER_RUN_REQUEST = 32'h1 << LPR_BIT;
    localparam logic [31:0] LOW_POWER_RUN_STATUS = 32'h1 << LOW_POWER_RUN_STATUS_BIT, FULL_REGULATION_WAKE = 32'h1 << FULL_REGULATION_WAKE_BIT;
    localparam logic [31:0] TODEN = 32'h1 << TODEN_BIT, STOP_ENTRY_PERMIT = 32'h1 << STOP_ENTRY_PERMIT_BIT;
    localparam logic [31:0] DEBUG_ENABLE_BIT = 32'h1 << DEBUG_ENABLE_BIT_BIT, EXTERNAL_BYPASS_LOW_POWER = 32'h1 << EXTERNAL_BYPASS_LOW_POWER_BIT;
    localparam logic [31:0] CSTOP = 32'h1, CMAWS = 32'h2, CBKGD = 32'h4;
    logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, pin_low = 0, ohigh = 0, slow = 0, pen = 0;
    logic [7:0]  haddr = 0, pin = 0, port = 0, pin_o;
    logic [1:0]  htrans = 0;
    logic [3:0]  src = 4'hf;
    logic [31:0] hwdata = 0, hrdata, rd;
    logic        hready, hresp, wpin, rsto, vec, irqv, ill, err, bkg, lat, pwr, regf, dclk, halt;
    smps_wake_s  irq;
    wire  [4:0]  pv = {bkg, err, ill, irqv, vec};
    int          n_mismatch = 0, n_compared = 0, v, cnt[5], base[5];

    always #20 clk = ~clk;
    always @(posedge clk) foreach (cnt[i]) if (pv[i] === 1'b1) cnt[i]++;

    smps_wake_model u_wake (.clk_i(clk), .pin_low_i(pin_low), .src_i(src), .wake_pin_o(wpin),
        .wake_irq_o(irq));
    smps_top dut (.CLK_SYS_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .WAKE_RESET_PIN_I(wpin), .WAKE_PIN_OUT_HIGH_I(ohigh), .SUPPLY_LOW_I(slow),
        .WAKE_IRQ_I(irq), .PERIPH_ENABLED_I(pen), .PIN_CTRL_I(pin), .PORT_CTRL_I(port),
        .PIN_CTRL_O(pin_o), .PIN_LATCHED_O(lat), .DOMAIN_POWER_O(pwr), .REGULATOR_FULL_O(regf),
        .DEBUG_CLK_ON_O(dclk), .CPU_HALT_O(halt), .MODULE_RESET_O(rsto), .RESET_VECTOR_O(vec),
        .IRQ_VECTOR_O(irqv), .ILLEGAL_RESET_O(ill), .DEBUG_STATUS_ERR_O(err),
        .BKGD_ENTRY_O(bkg));

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        settle(10);
        nrst <= 1'b1;
        settle(1);
    endtask
    // address phase, then data phase; read data is taken at the closing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        settle(3000);
        n_mismatch++;
        results();
    end

    initial begin
        do_reset();
        rchk(OFS_CTRL_ONE, CTRL_ONE_RST);
        rchk(OFS_SYS_OPT, SYS_OPT_RST);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        rchk(8'h20, 32'h0);
        base = cnt;
        bus(1'b1, OFS_CMD, CSTOP);
        settle(4);
        chk(32'(cnt[2] - base[2]), 32'h1);
        rchk(OFS_STATUS, 32'h0);
        $display("test reset and illegal stop done");
        // k 0 wakes by the pin after a masked attempt, k 1 by the time-of-day source
        for (int k = 0; k < 2; k++) begin
            pin <= 8'h5a;
            port <= 8'h3c;
            pen <= 1'b0;
            bus(1'b1, OFS_CTRL_TWO, k ? PARTIAL_POWERDOWN_CONTROL | TODEN : PARTIAL_POWERDOWN_CONTROL);
            bus(1'b1, OFS_SYS_OPT, STOP_ENTRY_PERMIT);
            bus(1'b1, OFS_CMD, CSTOP);
            settle(4);
            pin <= 8'ha5;
            port <= 8'hc3;
            ohigh <= !k;
            pin_low <= !k;
            slow <= 1'b1;
            settle(12);
            chk(pin_o, 8'h3c);
            chk({lat, pwr}, 2'b10);
            ohigh <= 1'b0;
            src <= k ? 4'd0 : 4'hf;
            settle(12);
            base = cnt;
            chk(rsto, 1'b1);
            slow <= 1'b0;
            pin_low <= 1'b0;
            src <= 4'hf;
            settle(20);
            chk(32'(cnt[0] - base[0]), 32'h1);
            rchk(OFS_STATUS, 32'h10);
            rchk(OFS_SYS_OPT, 32'h0);
            rchk(OFS_CTRL_TWO, POWERDOWN_RECOVERY_FLAG | (k ? PARTIAL_POWERDOWN_CONTROL | TODEN : PARTIAL_POWERDOWN_CONTROL));
            pen <= k;
            // clock and display setup would be rewritten here; this block owns neither
            bus(1'b1, OFS_CTRL_TWO, ACK);
            settle(4);
            chk({lat, pin_o}, {1'b0, k ? 8'ha5 : 8'hc3});
            rchk(OFS_CTRL_TWO, 32'h0);
        end
        $display("test powerdown stop done");
        // j 0 demotes by debug enable, j 1 by low voltage detect in stop
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, OFS_CTRL_ONE, j ? 32'h3 : 32'h0);
            bus(1'b1, OFS_CTRL_TWO, PARTIAL_POWERDOWN_CONTROL);
            bus(1'b1, OFS_SYS_OPT, j ? STOP_ENTRY_PERMIT : STOP_ENTRY_PERMIT | DEBUG_ENABLE_BIT);
            for (int s = 0; s < 10; s++) begin
                base = cnt;
                bus(1'b1, OFS_CMD, CSTOP);
                settle(4);
                rchk(OFS_STATUS, 32'h2);
                chk({regf, pwr, dclk}, {2'b11, j == 0});
                if (j == 0) begin
                    bus(1'b1, OFS_CMD, CMAWS);
                    bus(1'b1, OFS_CMD, CBKGD);
                    settle(4);
                    chk(32'(cnt[3] - base[3]), 32'h1);
                    chk(32'(cnt[4] - base[4]), 32'h1);
                    rchk(OFS_STATUS, 32'h5);
                    do_reset();
                    break;
                end
                if (s < 9)
                    src <= 4'(s);
                else
                    pin_low <= 1'b1;
                settle(8);
                src <= 4'hf;
                pin_low <= 1'b0;
                settle(16);
                v = (s == 9) ? 0 : 1;
                chk(32'(cnt[v] - base[v]), 32'h1);
                rchk(OFS_STATUS, 32'h0);
            end
        end
        $display("test retained stop done");
        bus(1'b1, OFS_CTRL_ONE, 32'h0);
        bus(1'b1, OFS_SYS_OPT, STOP_ENTRY_PERMIT | EXTERNAL_BYPASS_LOW_POWER);
        bus(1'b1, OFS_CTRL_TWO, PARTIAL_POWERDOWN_CONTROL);
        bus(1'b1, OFS_CTRL_TWO, PARTIAL_POWERDOWN_CONTROL | LOW_POWER_RUN_REQUEST);
        rchk(OFS_CTRL_TWO, PARTIAL_POWERDOWN_CONTROL);
        bus(1'b1, OFS_CTRL_TWO, 32'h0);
        bus(1'b1, OFS_CTRL_TWO, LOW_POWER_RUN_REQUEST);
        bus(1'b1, OFS_CTRL_TWO, LOW_POWER_RUN_REQUEST | PARTIAL_POWERDOWN_CONTROL);
        rchk(OFS_CTRL_TWO, LOW_POWER_RUN_REQUEST | LOW_POWER_RUN_STATUS);
        rchk(OFS_STATUS, 32'h1);
        for (int w = 0; w < 2; w++) begin
            bus(1'b1, OFS_CTRL_TWO, w ? LOW_POWER_RUN_REQUEST | FULL_REGULATION_WAKE : LOW_POWER_RUN_REQUEST);
            bus(1'b1, OFS_CMD, CSTOP);
            settle(4);
            src <= 4'd8;
            settle(8);
            src <= 4'hf;
            settle(8);
            rchk(OFS_STATUS, w ? 32'h0 : 32'h1);
            rchk(OFS_CTRL_TWO, w ? FULL_REGULATION_WAKE : LOW_POWER_RUN_REQUEST | LOW_POWER_RUN_STATUS);
        end
        $display("test low power run done");
        results();
    end
endmodule

// >>> bench/smps_wake_model.sv
// wake pin and interrupt source model for the stop sequencer bench
`timescale 1ns/1ps
module smps_wake_model
    import smps_pkg::*;
(
    // requests from the bench
    input  wire logic       clk_i,
    input  wire logic       pin_low_i,
    input  wire logic [3:0] src_i,
    // sources toward the sequencer
    output logic            wake_pin_o,
    output smps_wake_s      wake_irq_o
);
    // pin is an input with pull-up, so it idles high between wakes
    initial wake_pin_o = 1'b1;
    initial wake_irq_o = '0;
    always @(posedge clk_i) begin
        wake_pin_o <= !pin_low_i;
    end
    // a source holds its level until the bench withdraws it, like a pending flag
    always @(posedge clk_i) begin
        wake_irq_o <= (src_i < 4'd9) ? smps_wake_s'(9'h001 << src_i) : '0;
    end
endmodule

// >>> hw/smps_top.sv
// stop mode power sequencer with ahb-lite register slave
`timescale 1ns/1ps
//
// Overview of operation
// RL1: latch pin controls on powerdown stop entry (code: not when powerdown is entered from low-power run)
// RL2: powerdown stop cuts most domains' power
// RL3: wake pin low leaves powerdown stop
// RL4: enabled time-of-day interrupt wakes powerdown stop
// RL5: software makes wake pin input first
// RL6: high driven output wake pin ignored
// RL7: powerdown wake resets most module registers
// RL8: powerdown wake holds reset under low supply
// RL9: recovery flag stays until acknowledge written
// RL10: acknowledge opens pin latches to port values
// RL11: unenabled peripheral pins revert to port control
// RL12: software rewrites clock control before acknowledge
// RL13: software reinitialises display before acknowledge
// RL14: retained stop keeps all state
// RL15: reset or listed interrupts leave retained stop
// RL16: reset exit via reset vector, interrupt via own
// RL17: debug enable keeps debug clocks, full regulation
// RL18: debug enable demotes powerdown to retained stop
// RL19: stopped: status commands error, background wakes
// RL20: low voltage in stop keeps regulator, demotes
// RL21: low-power run and powerdown control exclusive (code: one write setting both bits from clear sets both)
// RL22: low-power run stop exit follows wake bit
// RL23: low-power run only under allowed conditions
// RL24: stop with permit clear forces illegal reset
module smps_top
    import smps_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [7:0]  HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // wake sources and pins
    input  wire logic        WAKE_RESET_PIN_I,
    input  wire logic        WAKE_PIN_OUT_HIGH_I,
    input  wire logic        SUPPLY_LOW_I,
    input  wire smps_wake_s  WAKE_IRQ_I,
    input  wire logic        PERIPH_ENABLED_I,
    // pin control from port logic
    input  wire logic [7:0]  PIN_CTRL_I,
    input  wire logic [7:0]  PORT_CTRL_I,
    // sequencer outputs
    output logic      [7:0]  PIN_CTRL_O,
    output logic             PIN_LATCHED_O,
    output logic             DOMAIN_POWER_O,
    output logic             REGULATOR_FULL_O,
    output logic             DEBUG_CLK_ON_O,
    output logic             CPU_HALT_O,
    output logic             MODULE_RESET_O,
    output logic             RESET_VECTOR_O,
    output logic             IRQ_VECTOR_O,
    output logic             ILLEGAL_RESET_O,
    output logic             DEBUG_STATUS_ERR_O,
    output logic             BKGD_ENTRY_O
);

    smps_mode_e mode;
    smps_mode_e resume_mode;
    logic [31:0] ctrl_one;
    logic [31:0] sys_opt;
    logic        partial_powerdown_control;
    logic        powerdown_recovery_flag;
    logic        low_power_run_request;
    logic        full_regulation_wake;
    logic        tod_en;
    logic        latched;
    logic [7:0]  pin_hold;
    logic [2:0]  wake_cnt;
    logic        wake_pin_m;
    logic        wake_pin_s;
    smps_wake_s  irq_m;
    smps_wake_s  irq_s;
    logic        supply_m;
    logic        supply_s;

    // ahb data phase
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_addr;
    logic        acc;

    logic lvd_stop;
    logic demote;
    logic stop_req;
    logic maws_req;
    logic bkgd_req;
    logic ack_wr;
    logic wake_pin_active;
    logic any_irq;

    assign acc = HSEL_I && HTRANS_I[1] && HREADY_I;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= 8'h00;
        end else if (HREADY_I) begin
            dp_wr   <= acc && HWRITE_I;
            dp_rd   <= acc && !HWRITE_I;
            dp_addr <= HADDR_I;
        end
    end

    // external levels cross into the bus clock domain
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wake_pin_m <= 1'b1;
            wake_pin_s <= 1'b1;
            irq_m      <= '0;
            irq_s      <= '0;
            supply_m   <= 1'b0;
            supply_s   <= 1'b0;
        end else begin
            wake_pin_m <= WAKE_RESET_PIN_I;
            wake_pin_s <= wake_pin_m;
            irq_m      <= WAKE_IRQ_I;
            irq_s      <= irq_m;
            supply_m   <= SUPPLY_LOW_I;
            supply_s   <= supply_m;
        end
    end

    assign lvd_stop = ctrl_one[LOW_VOLTAGE_DETECT_ENABLE_BIT] && ctrl_one[LOW_VOLTAGE_DETECT_IN_STOP_BIT];
    assign demote   = sys_opt[DEBUG_ENABLE_BIT_BIT] || lvd_stop; // RL18 RL20
    assign stop_req = dp_wr && dp_addr == OFS_CMD && HWDATA_I[CMD_STOP_BIT];
    assign maws_req = dp_wr && dp_addr == OFS_CMD && HWDATA_I[CMD_MAWS_BIT];
    assign bkgd_req = dp_wr && dp_addr == OFS_CMD && HWDATA_I[CMD_BKGD_BIT];
    assign ack_wr   = dp_wr && dp_addr == OFS_CTRL_TWO && HWDATA_I[POWERDOWN_ACKNOWLEDGE_BIT];
    // a high driven wake pin never reads as a wake request
    assign wake_pin_active = !wake_pin_s && !WAKE_PIN_OUT_HIGH_I; // RL3 RL6 RL5
    assign any_irq = |irq_s; // RL15

    // power mode sequencer
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mode        <= SMPS_RUN;
            resume_mode <= SMPS_RUN;
            wake_cnt    <= 3'h0;
        end else begin
            case (mode)
                SMPS_RUN, SMPS_LPRUN: begin
                    if (low_power_run_request && mode == SMPS_RUN) begin
                        mode <= SMPS_LPRUN;
                    end else if (!low_power_run_request && mode == SMPS_LPRUN) begin
                        mode <= SMPS_RUN;
                    end
                    if (stop_req && sys_opt[STOP_ENTRY_PERMIT_BIT]) begin
                        resume_mode <= mode;
                        // low-power run lands in stop3 unless one write set both lpr and partial_powerdown_control together
                        if (partial_powerdown_control && !demote) begin // RL18 RL20 RL21
                            mode <= SMPS_STOP2;
                        end else begin
                            mode <= SMPS_STOP3;
                        end
                    end
                end
                SMPS_STOP3: begin
                    if (wake_pin_active) begin
                        mode <= SMPS_RUN; // RL16 RL22
                    end else if (bkgd_req && sys_opt[DEBUG_ENABLE_BIT_BIT]) begin
                        mode <= SMPS_BKGD; // RL19
                    end else if (any_irq) begin
                        mode <= (resume_mode == SMPS_LPRUN && !full_regulation_wake) ? SMPS_LPRUN
                                                                      : SMPS_RUN; // RL22
                    end
                end
                SMPS_STOP2: begin
                    if (wake_pin_active || (tod_en && irq_s.time_of_day_unit)) begin // RL3 RL4
                        mode     <= SMPS_WAKE_RST;
                        wake_cnt <= 3'h0;
                    end
                end
                SMPS_WAKE_RST: begin
                    // reset stays while supply is below the trip point
                    if (supply_s) begin // RL8
                        wake_cnt <= 3'h0;
                    end else if (wake_cnt == 3'(WAKE_RESET_CYCLES - 1)) begin
                        mode <= SMPS_RUN;
                    end else begin
                        wake_cnt <= wake_cnt + 3'h1;
                    end
                end
                SMPS_BKGD: begin
                    if (stop_req) begin
                        mode <= SMPS_RUN;
                    end
                end
                default: mode <= SMPS_RUN;
            endcase
        end
    end

    // power_mgmt_ctrl_two bits; these survive a powerdown wake
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            partial_powerdown_control   <= 1'b0;
            low_power_run_request    <= 1'b0;
            full_regulation_wake  <= 1'b0;
            tod_en <= 1'b0;
        end else if (mode == SMPS_STOP3 && wake_pin_active) begin
            low_power_run_request <= 1'b0; // RL22
        end else if (mode == SMPS_STOP3 && any_irq && full_regulation_wake) begin
            low_power_run_request <= 1'b0; // RL22
        end else if (dp_wr && dp_addr == OFS_CTRL_TWO) begin
            full_regulation_wake  <= HWDATA_I[FULL_REGULATION_WAKE_BIT];
            tod_en <= HWDATA_I[TODEN_BIT];
            // each of partial_powerdown_control and lpr is refused while the other is set
            partial_powerdown_control <= HWDATA_I[PARTIAL_POWERDOWN_CONTROL_BIT] && !low_power_run_request; // RL21
            low_power_run_request  <= HWDATA_I[LPR_BIT] && !partial_powerdown_control && !sys_opt[DEBUG_ENABLE_BIT_BIT] && !lvd_stop
                    && sys_opt[EXTERNAL_BYPASS_LOW_POWER_BIT]; // RL21 RL23
        end
    end

    // recovery flag: the wake set wins over an acknowledge in the same cycle
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            powerdown_recovery_flag <= 1'b0;
        end else if (mode == SMPS_STOP2 && (wake_pin_active || (tod_en && irq_s.time_of_day_unit))) begin
            powerdown_recovery_flag <= 1'b1; // RL9
        end else if (ack_wr) begin
            powerdown_recovery_flag <= 1'b0; // RL9
        end
    end

    // module registers; a powerdown wake clears sys_opt but not ctrl_one
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_one <= CTRL_ONE_RST;
            sys_opt  <= SYS_OPT_RST;
        end else begin
            if (dp_wr && dp_addr == OFS_CTRL_ONE) begin
                ctrl_one <= HWDATA_I & 32'h0000_0003;
            end
            if (mode == SMPS_WAKE_RST) begin
                sys_opt <= SYS_OPT_RST; // RL7
            end else if (dp_wr && dp_addr == OFS_SYS_OPT) begin
                sys_opt <= HWDATA_I & 32'h0000_0007;
            end
        end
    end

    // pin latches close on powerdown entry from run, open on acknowledge
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            latched  <= 1'b0;
            pin_hold <= 8'h00;
        end else if (!latched && mode != SMPS_STOP2 && stop_req && sys_opt[STOP_ENTRY_PERMIT_BIT]
                     && partial_powerdown_control && !demote && mode == SMPS_RUN) begin
            latched  <= 1'b1; // RL1
            // hold what the pins show now, which may be port control rather than peripheral
            pin_hold <= PIN_CTRL_O;
        end else if (latched && ack_wr && mode != SMPS_STOP2 && mode != SMPS_WAKE_RST) begin
            latched <= 1'b0; // RL10
        end
    end

    // pins: held value, else peripheral if re-enabled, else port registers
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PIN_CTRL_O <= 8'h00;
        end else if (latched) begin
            PIN_CTRL_O <= pin_hold; // RL1 RL14
        end else if (PERIPH_ENABLED_I) begin
            PIN_CTRL_O <= PIN_CTRL_I;
        end else begin
            PIN_CTRL_O <= PORT_CTRL_I; // RL10 RL11
        end
    end

    // one-cycle event outputs
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RESET_VECTOR_O     <= 1'b0;
            IRQ_VECTOR_O       <= 1'b0;
            ILLEGAL_RESET_O    <= 1'b0;
            DEBUG_STATUS_ERR_O <= 1'b0;
            BKGD_ENTRY_O       <= 1'b0;
        end else begin
            RESET_VECTOR_O <= (mode == SMPS_STOP3 && wake_pin_active)
                              || (mode == SMPS_WAKE_RST && !supply_s
                                  && wake_cnt == 3'(WAKE_RESET_CYCLES - 1)); // RL8 RL16
            IRQ_VECTOR_O   <= mode == SMPS_STOP3 && !wake_pin_active
                              && !(bkgd_req && sys_opt[DEBUG_ENABLE_BIT_BIT]) && any_irq; // RL16
            ILLEGAL_RESET_O <= stop_req && !sys_opt[STOP_ENTRY_PERMIT_BIT]
                               && (mode == SMPS_RUN || mode == SMPS_LPRUN); // RL24
            DEBUG_STATUS_ERR_O <= maws_req && (mode == SMPS_STOP3); // RL19
            BKGD_ENTRY_O   <= bkgd_req && mode == SMPS_STOP3 && sys_opt[DEBUG_ENABLE_BIT_BIT]; // RL19
        end
    end

    assign PIN_LATCHED_O    = latched;
    assign DOMAIN_POWER_O   = mode != SMPS_STOP2; // RL2
    assign REGULATOR_FULL_O = !(mode == SMPS_STOP2 || mode == SMPS_LPRUN
                               || (mode == SMPS_STOP3 && !sys_opt[DEBUG_ENABLE_BIT_BIT]
                                   && !lvd_stop)); // RL17 RL20
    assign DEBUG_CLK_ON_O   = sys_opt[DEBUG_ENABLE_BIT_BIT] && mode != SMPS_STOP2; // RL17
    assign CPU_HALT_O       = mode == SMPS_STOP2 || mode == SMPS_STOP3 || mode == SMPS_WAKE_RST;
    assign MODULE_RESET_O   = mode == SMPS_WAKE_RST; // RL7 RL8

    // read mux, registered; unmapped addresses read zero with okay
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (acc && !HWRITE_I) begin
            case (HADDR_I)
                OFS_CTRL_ONE: HRDATA_O <= ctrl_one;
                OFS_CTRL_TWO: HRDATA_O <= {25'h0, tod_en, full_regulation_wake, low_power_run_request, low_power_run_request, powerdown_recovery_flag, 1'b0, partial_powerdown_control};
                OFS_SYS_OPT:  HRDATA_O <= sys_opt;
                OFS_STATUS:   HRDATA_O <= {27'h0, latched, 1'b0, mode};
                default:      HRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

endmodule

// >>> pkg/smps_pkg.sv
// package for the stop mode power sequencer: register map, fields, modes
package smps_pkg;

    // register byte offsets on the ahb-lite slave
    localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;  // power_mgmt_ctrl_one
    localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;  // power_mgmt_ctrl_two
    localparam logic [7:0] OFS_SYS_OPT   = 8'h08;  // stop_entry_permit and debug_enable_bit
    localparam logic [7:0] OFS_STATUS    = 8'h0c;  // mode and pin latch status, read only
    localparam logic [7:0] OFS_CMD       = 8'h10;  // stop instruction and debug commands

    // power_mgmt_ctrl_one fields
    localparam int LOW_VOLTAGE_DETECT_ENABLE_BIT   = 0;
    localparam int LOW_VOLTAGE_DETECT_IN_STOP_BIT  = 1;
    // power_mgmt_ctrl_two fields
    localparam int PARTIAL_POWERDOWN_CONTROL_BIT   = 0;
    localparam int POWERDOWN_ACKNOWLEDGE_BIT = 1;
    localparam int POWERDOWN_RECOVERY_FLAG_BIT   = 2;
    localparam int LPR_BIT    = 3;
    localparam int LOW_POWER_RUN_STATUS_BIT   = 4;
    localparam int FULL_REGULATION_WAKE_BIT  = 5;
    localparam int TODEN_BIT  = 6;
    // system option fields
    localparam int STOP_ENTRY_PERMIT_BIT  = 0;
    localparam int DEBUG_ENABLE_BIT_BIT  = 1;
    localparam int EXTERNAL_BYPASS_LOW_POWER_BIT  = 2;
    // command fields
    localparam int CMD_STOP_BIT = 0;
    localparam int CMD_MAWS_BIT = 1;
    localparam int CMD_BKGD_BIT = 2;

    localparam logic [31:0] CTRL_ONE_RST = 32'h0000_0000;
    localparam logic [31:0] SYS_OPT_RST  = 32'h0000_0000;

    // number of wake interrupt sources for retained stop
    localparam int NUM_WAKE_SRC = 9;
    // cycles held in reset after a powerdown wake, supply ramp allowance
    localparam int WAKE_RESET_CYCLES = 4;

    typedef enum logic [2:0] {
        SMPS_RUN,
        SMPS_LPRUN,
        SMPS_STOP3,
        SMPS_STOP2,
        SMPS_WAKE_RST,
        SMPS_BKGD
    } smps_mode_e;

    // wake source bundle, one bit each
    typedef struct packed {
        logic keyboard_interrupt;
        logic lcd;
        logic sci;
        logic irq;
        logic analog_comparator;
        logic adc;
        logic low_voltage_warning;
        logic lvd;
        logic time_of_day_unit;
    } smps_wake_s;

endpackage
